// file: mifu_top.sv
// Inactivity based free fall detector and the two interrupt pin drivers.
// Assumes samples and register accesses arrive on clk from logic in the same domain.
module mifu_top #(
    parameter int SETTLE_COUNT = mifu_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sample stream
    input wire logic sample_valid,
    input wire mifu_pkg::mifu_sample_t sample,
    input wire logic meas_mode,
    input wire logic [7:0] other_events,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Interrupt pins
    output mifu_pkg::mifu_pin_t irq_pin_a,
    output mifu_pkg::mifu_pin_t irq_pin_b
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] magnitude(input logic signed [15:0] v);
        magnitude = v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic mifu_pkg::mifu_pin_t pin_next(input logic [7:0] map, input logic [7:0] src,
                                                     input logic pol, input logic keep);
        pin_next.oe = |map;
        pin_next.o = (|map) ? ((|(map & src)) ^ pol) : keep;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] map_a_q, map_a_d, map_b_q, map_b_d, ctl_q, ctl_d, axis_q, axis_d;
    logic [7:0] cfg_a_q, cfg_a_d, cfg_b_q, cfg_b_d;
    logic [15:0] thr_q, thr_d;
    logic [23:0] dur_q, dur_d;
    logic [7:0] rdata_q, rdata_d;
    logic still_flag_q, still_flag_d;
    logic [23:0] cnt_q, cnt_d;
    logic [31:0] settle_q, settle_d;
    logic meas_q, meas_d;
    mifu_pkg::mifu_pin_t pa_q, pa_d, pb_q, pb_d;
    logic settled, below, still_event;
    logic [7:0] sources;

    assign settled = settle_q == 32'(SETTLE_COUNT);
    // Magnitude compare on each enabled axis; no axis enabled never qualifies.
    assign below = (|axis_q[2:0])
        && (!axis_q[0] || magnitude(sample.x) < thr_q)
        && (!axis_q[1] || magnitude(sample.y) < thr_q)
        && (!axis_q[2] || magnitude(sample.z) < thr_q);
    // Only absolute mode flags, and only once the output has settled.
    assign still_event = sample_valid && settled && ctl_q[mifu_pkg::CTL_EN_BIT]
        && !ctl_q[mifu_pkg::CTL_REF_BIT] && below
        && (cnt_q + 24'h000001 == (dur_q == 24'h000000 ? 24'h000001 : dur_q));

    always_comb
    begin
        map_a_d = map_a_q;
        map_b_d = map_b_q;
        ctl_d = ctl_q;
        axis_d = axis_q;
        cfg_a_d = cfg_a_q;
        cfg_b_d = cfg_b_q;
        thr_d = thr_q;
        dur_d = dur_q;
        rdata_d = rdata_q;
        if (reg_wr)
        begin
            unique case (reg_addr)
                mifu_pkg::ADDR_MAP_A: map_a_d = reg_wdata;
                mifu_pkg::ADDR_MAP_B: map_b_d = reg_wdata;
                mifu_pkg::ADDR_CTL: ctl_d = reg_wdata;
                mifu_pkg::ADDR_AXIS: axis_d = reg_wdata;
                mifu_pkg::ADDR_THR_HI: thr_d[15:8] = reg_wdata;
                mifu_pkg::ADDR_THR_LO: thr_d[7:0] = reg_wdata;
                mifu_pkg::ADDR_TIME_HI: dur_d[23:16] = reg_wdata;
                mifu_pkg::ADDR_TIME_MID: dur_d[15:8] = reg_wdata;
                mifu_pkg::ADDR_TIME_LO: dur_d[7:0] = reg_wdata;
                mifu_pkg::ADDR_CFG_A: cfg_a_d = reg_wdata;
                mifu_pkg::ADDR_CFG_B: cfg_b_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                mifu_pkg::ADDR_STATUS: rdata_d = 8'({still_flag_q, 6'h00});
                mifu_pkg::ADDR_MAP_A: rdata_d = map_a_q;
                mifu_pkg::ADDR_MAP_B: rdata_d = map_b_q;
                mifu_pkg::ADDR_CTL: rdata_d = ctl_q;
                mifu_pkg::ADDR_AXIS: rdata_d = axis_q;
                mifu_pkg::ADDR_THR_HI: rdata_d = thr_q[15:8];
                mifu_pkg::ADDR_THR_LO: rdata_d = thr_q[7:0];
                mifu_pkg::ADDR_TIME_HI: rdata_d = dur_q[23:16];
                mifu_pkg::ADDR_TIME_MID: rdata_d = dur_q[15:8];
                mifu_pkg::ADDR_TIME_LO: rdata_d = dur_q[7:0];
                mifu_pkg::ADDR_CFG_A: rdata_d = cfg_a_q;
                mifu_pkg::ADDR_CFG_B: rdata_d = cfg_b_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            map_a_q <= mifu_pkg::RESET_BYTE;
            map_b_q <= mifu_pkg::RESET_BYTE;
            ctl_q <= mifu_pkg::RESET_BYTE;
            axis_q <= mifu_pkg::RESET_BYTE;
            cfg_a_q <= mifu_pkg::RESET_BYTE;
            cfg_b_q <= mifu_pkg::RESET_BYTE;
            thr_q <= 16'h0000;
            dur_q <= 24'h000000;
            rdata_q <= 8'h00;
        end
        else
        begin
            map_a_q <= map_a_d;
            map_b_q <= map_b_d;
            ctl_q <= ctl_d;
            axis_q <= axis_d;
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
            thr_q <= thr_d;
            dur_q <= dur_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Detector and settling timer
    // ------------------------------------------------------------
    always_comb
    begin
        meas_d = meas_mode;
        settle_d = settle_q;
        // Entering measurement mode restarts the settling wait.
        if (!meas_mode || (meas_mode && !meas_q))
        begin
            settle_d = 32'h00000000;
        end
        else if (!settled)
        begin
            settle_d = settle_q + 32'h00000001;
        end
        cnt_d = cnt_q;
        if (sample_valid)
        begin
            // A failing sample restarts; the count saturates at 24'hffffff.
            if (!below || !settled)
            begin
                cnt_d = 24'h000000;
            end
            else if (cnt_q != 24'hffffff)
            begin
                cnt_d = cnt_q + 24'h000001;
            end
        end
        // Status read clears, but a same cycle detection wins.
        still_flag_d = still_event || (still_flag_q && !(reg_rd
            && reg_addr == mifu_pkg::ADDR_STATUS));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meas_q <= 1'b0;
            settle_q <= 32'h00000000;
            cnt_q <= 24'h000000;
            still_flag_q <= 1'b0;
        end
        else
        begin
            meas_q <= meas_d;
            settle_q <= settle_d;
            cnt_q <= cnt_d;
            still_flag_q <= still_flag_d;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // The inactivity source is the sticky flag, so the pin stays active until software reads it.
    always_comb
    begin
        sources = other_events;
        sources[mifu_pkg::STILL_BIT] = still_flag_q;
        pa_d = pin_next(map_a_q, sources, cfg_a_q[mifu_pkg::POL_BIT], pa_q.o);
        pb_d = pin_next(map_b_q, sources, cfg_b_q[mifu_pkg::POL_BIT], pb_q.o);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pa_q <= '0;
            pb_q <= '0;
        end
        else
        begin
            pa_q <= pa_d;
            pb_q <= pb_d;
        end
    end

    assign irq_pin_a = pa_q;
    assign irq_pin_b = pb_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_flag_needs_settle;
        @(posedge clk) disable iff (rst) $rose(still_flag_q) |-> $past(settled);
    endproperty
    a_flag_needs_settle: assert property (p_flag_needs_settle) else $error("early flag");

    property p_flag_on_event;
        @(posedge clk) disable iff (rst) still_event |=> still_flag_q;
    endproperty
    a_flag_on_event: assert property (p_flag_on_event) else $error("event lost");

    property p_flag_cause;
        @(posedge clk) disable iff (rst) $rose(still_flag_q) |-> $past(below && sample_valid);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without quiet sample");

    property p_count_restart;
        @(posedge clk) disable iff (rst) (sample_valid && !below) |=> cnt_q == 24'h000000;
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("count not restarted");

    property p_unmapped_release;
        @(posedge clk) disable iff (rst) (map_b_q == 8'h00) |=> !irq_pin_b.oe;
    endproperty
    a_unmapped_release: assert property (p_unmapped_release) else $error("pin b driven");

    property p_reset_release;
        @(posedge clk) rst |=> !irq_pin_a.oe && !irq_pin_b.oe;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("driven after reset");

    property p_route_level;
        @(posedge clk) disable iff (rst) (map_a_q[mifu_pkg::STILL_BIT] && still_flag_q)
            |=> irq_pin_a.oe && irq_pin_a.o == !$past(cfg_a_q[mifu_pkg::POL_BIT]);
    endproperty
    a_route_level: assert property (p_route_level) else $error("pin a level wrong");

    property p_keeper;
        @(posedge clk) disable iff (rst) (!irq_pin_b.oe && map_b_q == 8'h00)
            |=> $stable(irq_pin_b.o);
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper level moved");

    property p_idle_level;
        @(posedge clk) disable iff (rst) ((map_a_q != 8'h00) && !(|(map_a_q & sources)))
            |=> irq_pin_a.o == $past(cfg_a_q[mifu_pkg::POL_BIT]);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("pin a idle level wrong");

endmodule

// file: mifu_pkg.sv
// Constants, register map and carrier types of the motion interrupt and free fall unit.
// Assumes a single 100 MHz clock and a byte-wide register port from the serial front end.
package mifu_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h11;
    localparam logic [7:0] ADDR_MAP_A = 8'h2b;
    localparam logic [7:0] ADDR_MAP_B = 8'h2d;
    localparam logic [7:0] ADDR_CTL = 8'h37;
    localparam logic [7:0] ADDR_AXIS = 8'h38;
    localparam logic [7:0] ADDR_THR_HI = 8'h3e;
    localparam logic [7:0] ADDR_THR_LO = 8'h3f;
    localparam logic [7:0] ADDR_TIME_HI = 8'h40;
    localparam logic [7:0] ADDR_TIME_MID = 8'h41;
    localparam logic [7:0] ADDR_TIME_LO = 8'h42;
    localparam logic [7:0] ADDR_CFG_A = 8'h5d;
    localparam logic [7:0] ADDR_CFG_B = 8'h5e;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int STILL_BIT = 6;
    localparam int CTL_EN_BIT = 2;
    localparam int CTL_REF_BIT = 3;
    localparam int POL_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_MS = 2;
    localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } mifu_sample_t;

    typedef struct packed {
        logic o;
        logic oe;
    } mifu_pin_t;

endpackage

// file: mifu_host_model.sv
// Host side of the two interrupt lines, seen as wires with keepers.
// Assumes the pins change only on clk; the line is sampled one clock later.
module mifu_host_model (
    // Clock
    input wire logic clk,
    // Pins from the device
    input wire mifu_pkg::mifu_pin_t pin_a,
    input wire mifu_pkg::mifu_pin_t pin_b,
    // Line levels seen by the host
    output logic line_a,
    output logic line_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released line keeps its last driven level, so no pull is modelled.
    always_ff @(posedge clk)
    begin
        if (pin_a.oe)
        begin
            line_a <= pin_a.o;
        end
        if (pin_b.oe)
        begin
            line_b <= pin_b.o;
        end
    end
endmodule

// file: mifu_top_tb.sv
// Self-checking bench of the free fall detector and interrupt pins.
// Assumes mifu_pkg, mifu_top and mifu_host_model are compiled first.
module mifu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    mifu_pkg::mifu_sample_t sample = '0;
    logic meas_mode = 1'b1;
    logic [7:0] other_events = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    mifu_pkg::mifu_pin_t irq_pin_a;
    mifu_pkg::mifu_pin_t irq_pin_b;
    logic line_a;
    logic line_b;
    logic [7:0] rv;
    int error_cnt = 0;
    int checked = 0;

    always #5 clk = ~clk;

    mifu_top #(.SETTLE_COUNT(SETTLE)) u_mifu_top (.clk(clk), .rst(rst),
        .sample_valid(sample_valid), .sample(sample), .meas_mode(meas_mode),
        .other_events(other_events), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
    mifu_host_model u_mifu_host_model (.clk(clk), .pin_a(irq_pin_a), .pin_b(irq_pin_b),
        .line_a(line_a), .line_b(line_b));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Each access ends with an idle cycle so no strobe is set twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    task automatic rd(input logic [7:0] a);
        reg_rd = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        rv = reg_rdata;
        tick();
    endtask

    task automatic smp(input logic [47:0] v);
        sample_valid = 1'b1;
        sample = v;
        tick();
        sample_valid = 1'b0;
        tick();
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({6'h00, irq_pin_a}, 8'h00);
        chk({6'h00, irq_pin_b}, 8'h00);
        rd(mifu_pkg::ADDR_STATUS);
        chk(rv, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [7:0] addrs [6];
        addrs = '{8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h5d};
        foreach (addrs[i])
        begin
            rd(addrs[i]);
            chk(rv, mifu_pkg::RESET_BYTE);
            wr(addrs[i], addrs[i] ^ 8'h5a);
            rd(addrs[i]);
            chk(rv, addrs[i] ^ 8'h5a);
            wr(addrs[i], 8'h00);
        end
        wr(8'h50, 8'hff);
        rd(8'h50);
        chk(rv, 8'h00);
        wr(mifu_pkg::ADDR_STATUS, 8'hff);
        rd(mifu_pkg::ADDR_STATUS);
        chk(rv, 8'h00);
        $display("test registers done");
    endtask

    // Quiet has a negative axis just inside and a loud disabled axis; the
    // failing sample sits exactly on the threshold, so it must not qualify.
    task automatic t_fall();
        repeat (SETTLE) tick();
        wr(mifu_pkg::ADDR_AXIS, 8'h03);
        wr(mifu_pkg::ADDR_THR_LO, 8'h80);
        wr(mifu_pkg::ADDR_TIME_LO, 8'h03);
        wr(mifu_pkg::ADDR_MAP_B, 8'h40);
        wr(mifu_pkg::ADDR_CTL, 8'h04);
        chk({6'h00, irq_pin_b}, 8'h01);
        smp({16'hff81, 16'h007f, 16'h7fff});
        smp({16'h0000, 16'hff80, 16'h0000});
        smp({16'hff81, 16'h007f, 16'h7fff});
        smp({16'hff81, 16'h007f, 16'h7fff});
        tick();
        chk({6'h00, irq_pin_b}, 8'h01);
        smp({16'hff81, 16'h007f, 16'h7fff});
        tick();
        chk({6'h00, irq_pin_b}, 8'h03);
        chk({6'h00, irq_pin_a}, 8'h00);
        wr(mifu_pkg::ADDR_CFG_B, 8'h80);
        chk({6'h00, irq_pin_b}, 8'h01);
        rd(mifu_pkg::ADDR_STATUS);
        chk(rv, 8'h40);
        chk({6'h00, irq_pin_b}, 8'h03);
        wr(mifu_pkg::ADDR_MAP_B, 8'h00);
        chk({6'h00, irq_pin_b}, 8'h02);
        chk({7'h00, line_b}, 8'h01);
        rd(mifu_pkg::ADDR_STATUS);
        chk(rv, 8'h00);
        $display("test free fall done");
    endtask

    task automatic t_or();
        wr(mifu_pkg::ADDR_MAP_A, 8'h03);
        wr(mifu_pkg::ADDR_MAP_B, 8'h02);
        other_events = 8'h02;
        tick();
        chk({6'h00, irq_pin_a}, 8'h03);
        chk({6'h00, irq_pin_b}, 8'h01);
        other_events = 8'h01;
        tick();
        chk({6'h00, irq_pin_a}, 8'h03);
        other_events = 8'h00;
        tick();
        tick();
        chk({6'h00, irq_pin_a}, 8'h01);
        chk({7'h00, line_a}, 8'h00);
        $display("test pin routing done");
    endtask

    // Referenced mode and samples taken before the output settles must both stay silent;
    // a reset in mid-run must release a driven pin.
    task automatic t_hold();
        wr(mifu_pkg::ADDR_CTL, 8'h0c);
        wr(mifu_pkg::ADDR_MAP_A, 8'h40);
        smp({16'h0000, 16'h0100, 16'h0000});
        repeat (3) smp({16'hff81, 16'h007f, 16'h7fff});
        tick();
        chk({6'h00, irq_pin_a}, 8'h01);
        wr(mifu_pkg::ADDR_CTL, 8'h04);
        meas_mode = 1'b0;
        tick();
        meas_mode = 1'b1;
        repeat (3) smp({16'hff81, 16'h007f, 16'h7fff});
        tick();
        chk({6'h00, irq_pin_a}, 8'h01);
        repeat (SETTLE) tick();
        repeat (3) smp({16'hff81, 16'h007f, 16'h7fff});
        tick();
        chk({6'h00, irq_pin_a}, 8'h03);
        rd(mifu_pkg::ADDR_STATUS);
        chk(rv, 8'h40);
        rst = 1'b1;
        tick();
        tick();
        chk({6'h00, irq_pin_a}, 8'h00);
        chk({6'h00, irq_pin_b}, 8'h00);
        rst = 1'b0;
        tick();
        rd(mifu_pkg::ADDR_MAP_A);
        chk(rv, mifu_pkg::RESET_BYTE);
        $display("test hold-off and reset done");
    endtask

    initial
    begin
        #20us;
        $display("ERROR %0t: watchdog expired", $time);
        error_cnt++;
        final_report();
    end

    initial
    begin
        repeat (20) tick();
        rst = 1'b0;
        tick();
        t_reset();
        t_regs();
        t_fall();
        t_or();
        t_hold();
        final_report();
    end
endmodule
